// ==== resampler_pkg.sv ====
// Summary of operation
// - Residual whole-sample delay from on-chip sample buffer.
// - Re-sample to target rate, then frequency shift.
// - Every antenna stream leaves at common rate.
// - Fine delay offsets the interpolation position.
// - Fractional delay in 1024 steps, +/-0.5 sample.
// - Fractional delay LSB scrambled by dither.
// - Phase rotation before any downstream processing.
// - 18-bit rotation, phase LSB dithered before lookup.
// - Per-beam true-delay steering inside the re-sampler.
`default_nettype none
package resampler_pkg;

  localparam int SAMP_W = 16;
  localparam int OUT_W = 18;
  localparam int FRAC_W = 10;
  localparam int POS_FRAC_W = 20;
  localparam int RATE_W = 24;
  localparam int PHASE_W = 18;
  localparam int COEF_W = 18;
  localparam int MAG_W = 17;
  localparam int LUT_ADDR_W = 6;
  localparam int QUART_W = 4;
  localparam int BUF_AW = 12;
  localparam int BUF_DEPTH = 4096;
  localparam int CNT_W = 32;
  localparam int RP_W = CNT_W + FRAC_W;
  localparam int NUM_BEAMS = 4;
  localparam int BEAM_W = 2;
  localparam int BDLY_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int LFSR_W = 16;
  localparam int DELAY_DITHER_BIT = 0;
  localparam int PHASE_DITHER_BIT = 1;
  localparam int ROT_SHIFT = COEF_W - 1;

  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic signed [CNT_W-1:0] MIN_AHEAD = 32'sh2;
  localparam logic signed [CNT_W-1:0] MAX_AHEAD = 32'sh1000;
  localparam logic signed [CNT_W-1:0] IN_LIMIT = 32'shFFE;
  localparam logic [QUART_W:0] QUART_FULL = 5'h10;
  localparam logic [LUT_ADDR_W-1:0] QUARTER_TURN = 6'h10;
  localparam logic [BEAM_W-1:0] LAST_BEAM = 2'h3;

  // Quarter sine wave, full scale 2^17-1
  localparam logic [MAG_W-1:0] SINE_QUARTER [0:16] = '{
    17'h00000, 17'h0322F, 17'h063E3, 17'h094A0, 17'h0C3EF, 17'h0F15B,
    17'h11C73, 17'h144CF, 17'h16A09, 17'h18BC7, 17'h1A9B6, 17'h1C38A,
    17'h1D906, 17'h1E9F4, 17'h1F629, 17'h1FD88, 17'h1FFFF
  };

  typedef struct packed {
    logic signed [SAMP_W-1:0] re;
    logic signed [SAMP_W-1:0] im;
  } sample_t;

  typedef struct packed {
    logic [BEAM_W-1:0] beam;
    logic signed [OUT_W-1:0] re;
    logic signed [OUT_W-1:0] im;
  } out_sample_t;

  typedef struct packed {
    logic signed [BDLY_W-1:0] delay;
    logic [PHASE_W-1:0] phase;
  } beam_model_t;

  typedef enum {S_CALC, S_RD0, S_RD1, S_INTERP, S_ROT, S_PUSH} state_t;

endpackage
`default_nettype wire

// ==== sample_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [WIDTH-1:0] next_slot [DEPTH];
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] fill_pos;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign fill_pos = cnt - CW'(pop);
  assign out_data = slot[0];

  // Head sits in slot 0, entries shift down on each pop
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_slot
      always_comb
      begin
        next_slot[i] = slot[i];
        if (pop)
        begin
          if (i < DEPTH - 1)
            next_slot[i] = slot[(i < DEPTH - 1) ? i + 1 : i];
        end
        if (push && fill_pos == CW'(i))
          next_slot[i] = in_data;
      end

      always_ff @(posedge clk)
      begin
        if (rst)
          slot[i] <= '0;
        else
          slot[i] <= next_slot[i];
      end
    end
  endgenerate

  assign next_cnt = cnt + CW'(push) - CW'(pop);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      in_ready <= (next_cnt != CW'(DEPTH));
      out_valid <= (next_cnt != '0);
    end
  end
endmodule // sample_fifo
`default_nettype wire

// ==== delay_phase_resampler.sv ====
`timescale 1ns/1ps
`default_nettype none
module delay_phase_resampler
  import resampler_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic IN_VALID,
  input wire sample_t IN_DATA,
  output logic IN_READY,
  input wire logic [BUF_AW-1:0] COARSE_DELAY,
  input wire logic signed [FRAC_W-1:0] FINE_DELAY,
  input wire logic [RATE_W-1:0] RATE_STEP,
  input wire logic [PHASE_W-1:0] FREQ_STEP,
  input wire logic [PHASE_W-1:0] PHASE_OFFSET,
  input wire beam_model_t [NUM_BEAMS-1:0] BEAM_MODEL,
  output logic OUT_VALID,
  output out_sample_t OUT_DATA,
  input wire logic OUT_READY,
  output logic RANGE_ERR
);

  // Signed sine from the quarter-wave table
  function automatic logic signed [COEF_W-1:0] sine_of(input logic [LUT_ADDR_W-1:0] idx);
    logic [QUART_W:0] m;
    logic signed [COEF_W-1:0] mag;
    m = {1'b0, idx[QUART_W-1:0]};
    if (idx[LUT_ADDR_W-2])
      m = QUART_FULL - m;
    mag = COEF_W'(signed'({1'b0, SINE_QUARTER[m]}));
    if (idx[LUT_ADDR_W-1])
      sine_of = -mag;
    else
      sine_of = mag;
  endfunction

  // Sample buffer and write side
  sample_t mem [0:BUF_DEPTH-1];
  sample_t mem_q;
  logic [BUF_AW-1:0] mem_raddr;
  logic wr_en;
  logic [CNT_W-1:0] wr_cnt;
  logic [CNT_W-1:0] next_wr_cnt;
  logic in_ready;
  logic next_in_ready;

  // Engine state
  state_t state;
  state_t next_state;
  logic [CNT_W+POS_FRAC_W-1:0] pos;
  logic [CNT_W+POS_FRAC_W-1:0] next_pos;
  logic [PHASE_W-1:0] freq_acc;
  logic [PHASE_W-1:0] next_freq_acc;
  logic [BEAM_W-1:0] beam;
  logic [BEAM_W-1:0] next_beam;
  logic [CNT_W-1:0] rd_int;
  logic [CNT_W-1:0] next_rd_int;
  logic [FRAC_W-1:0] rd_frac;
  logic [FRAC_W-1:0] next_rd_frac;
  logic rd_zero;
  logic next_rd_zero;
  sample_t x0;
  sample_t next_x0;
  logic signed [OUT_W-1:0] yi;
  logic signed [OUT_W-1:0] yq;
  logic signed [OUT_W-1:0] next_yi;
  logic signed [OUT_W-1:0] next_yq;
  out_sample_t res;
  out_sample_t next_res;
  logic [LFSR_W-1:0] lfsr;
  logic [LFSR_W-1:0] next_lfsr;
  logic range_err;
  logic next_range_err;
  logic push_valid;
  logic fifo_in_ready;

  // Arithmetic helpers
  logic signed [RP_W-1:0] delay_fx;
  logic signed [RP_W-1:0] pos_fx;
  logic signed [RP_W-1:0] rp;
  logic signed [CNT_W-1:0] ahead;
  logic [PHASE_W-1:0] ph;
  logic [PHASE_W-1:0] ph_d;
  logic [LUT_ADDR_W-1:0] lut_idx;
  logic signed [COEF_W-1:0] cos_c;
  logic signed [COEF_W-1:0] sin_c;
  logic signed [SAMP_W:0] di;
  logic signed [SAMP_W:0] dq;
  logic signed [SAMP_W+FRAC_W+1:0] pi_m;
  logic signed [SAMP_W+FRAC_W+1:0] pq_m;
  logic signed [OUT_W+COEF_W:0] rot_re;
  logic signed [OUT_W+COEF_W:0] rot_im;

  assign wr_en = IN_VALID & in_ready;

  // Input side: accept while buffer has room behind the read point
  always_comb
  begin
    next_wr_cnt = wr_cnt;
    if (wr_en)
      next_wr_cnt = wr_cnt + 1'b1;
    next_in_ready = signed'(next_wr_cnt - rd_int) < IN_LIMIT;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      wr_cnt <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      wr_cnt <= next_wr_cnt;
      in_ready <= next_in_ready;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (wr_en)
      mem[wr_cnt[BUF_AW-1:0]] <= IN_DATA;
    mem_q <= mem[mem_raddr];
  end

  always_comb
  begin
    delay_fx = signed'(RP_W'({COARSE_DELAY, {FRAC_W{1'b0}}}));
    // fine delay, +/-0.5 sample in 1024 steps
    delay_fx = delay_fx + RP_W'(FINE_DELAY);
    delay_fx = delay_fx + RP_W'(BEAM_MODEL[beam].delay);
    delay_fx[0] = delay_fx[0] ^ lfsr[DELAY_DITHER_BIT];
    pos_fx = signed'(pos[CNT_W+POS_FRAC_W-1:POS_FRAC_W-FRAC_W]);
    rp = pos_fx - delay_fx;
    ahead = signed'(wr_cnt - rp[RP_W-1:FRAC_W]);

    ph = freq_acc + PHASE_OFFSET + BEAM_MODEL[beam].phase;
    ph_d = {ph[PHASE_W-1:1], ph[0] ^ lfsr[PHASE_DITHER_BIT]};
    lut_idx = ph_d[PHASE_W-1:PHASE_W-LUT_ADDR_W];
    cos_c = sine_of(lut_idx + QUARTER_TURN);
    sin_c = sine_of(lut_idx);

    // linear interpolation at the offset position
    di = (SAMP_W + 1)'(mem_q.re) - (SAMP_W + 1)'(x0.re);
    dq = (SAMP_W + 1)'(mem_q.im) - (SAMP_W + 1)'(x0.im);
    pi_m = di * signed'({1'b0, rd_frac});
    pq_m = dq * signed'({1'b0, rd_frac});

    rot_re = (OUT_W + COEF_W + 1)'(yi * cos_c) - (OUT_W + COEF_W + 1)'(yq * sin_c);
    rot_im = (OUT_W + COEF_W + 1)'(yi * sin_c) + (OUT_W + COEF_W + 1)'(yq * cos_c);
  end

  // Engine: one interpolated, rotated sample per beam per output instant
  always_comb
  begin
    next_state = state;
    next_pos = pos;
    next_freq_acc = freq_acc;
    next_beam = beam;
    next_rd_int = rd_int;
    next_rd_frac = rd_frac;
    next_rd_zero = rd_zero;
    next_x0 = x0;
    next_yi = yi;
    next_yq = yq;
    next_res = res;
    next_lfsr = lfsr;
    next_range_err = range_err;
    mem_raddr = rd_int[BUF_AW-1:0];
    push_valid = 1'b0;
    case (state)
      S_CALC:
      begin
        next_rd_int = rp[RP_W-1:FRAC_W];
        next_rd_frac = rp[FRAC_W-1:0];
        // wait until both neighbours are stored
        if (ahead < MIN_AHEAD)
          next_state = S_CALC;
        else if (ahead > MAX_AHEAD)
        begin
          next_rd_zero = 1'b1;
          next_range_err = 1'b1;
          next_state = S_INTERP;
        end
        else
        begin
          next_rd_zero = 1'b0;
          next_range_err = 1'b0;
          next_state = S_RD0;
        end
      end
      S_RD0:
      begin
        mem_raddr = rd_int[BUF_AW-1:0];
        next_state = S_RD1;
      end
      S_RD1:
      begin
        mem_raddr = rd_int[BUF_AW-1:0] + 1'b1;
        next_x0 = mem_q;
        next_state = S_INTERP;
      end
      S_INTERP:
      begin
        if (rd_zero)
        begin
          next_yi = '0;
          next_yq = '0;
        end
        else
        begin
          next_yi = OUT_W'(x0.re) + OUT_W'(pi_m >>> FRAC_W);
          next_yq = OUT_W'(x0.im) + OUT_W'(pq_m >>> FRAC_W);
        end
        next_state = S_ROT;
      end
      S_ROT:
      begin
        next_res.beam = beam;
        next_res.re = rot_re[ROT_SHIFT+OUT_W-1:ROT_SHIFT];
        next_res.im = rot_im[ROT_SHIFT+OUT_W-1:ROT_SHIFT];
        next_state = S_PUSH;
      end
      S_PUSH:
      begin
        push_valid = 1'b1;
        if (fifo_in_ready)
        begin
          // advance dither once per output sample
          next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
          if (beam == LAST_BEAM)
          begin
            next_beam = '0;
            // step to the common output rate
            next_pos = pos + (CNT_W + POS_FRAC_W)'(RATE_STEP);
            next_freq_acc = freq_acc + FREQ_STEP;
          end
          else
          begin
            next_beam = beam + 1'b1;
          end
          next_state = S_CALC;
        end
      end
      default:
      begin
        next_state = S_CALC;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state <= S_CALC;
      pos <= '0;
      freq_acc <= '0;
      beam <= '0;
      rd_int <= '0;
      rd_frac <= '0;
      rd_zero <= 1'b0;
      x0 <= '0;
      yi <= '0;
      yq <= '0;
      res <= '0;
      lfsr <= LFSR_SEED;
      range_err <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pos <= next_pos;
      freq_acc <= next_freq_acc;
      beam <= next_beam;
      rd_int <= next_rd_int;
      rd_frac <= next_rd_frac;
      rd_zero <= next_rd_zero;
      x0 <= next_x0;
      yi <= next_yi;
      yq <= next_yq;
      res <= next_res;
      lfsr <= next_lfsr;
      range_err <= next_range_err;
    end
  end

  assign IN_READY = in_ready;
  assign RANGE_ERR = range_err;

  // Output buffer; downstream stall holds the engine in S_PUSH
  sample_fifo #(
    .WIDTH($bits(out_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .clk(CLK),
    .rst(SYS_RST),
    .in_valid(push_valid),
    .in_data(res),
    .in_ready(fifo_in_ready),
    .out_valid(OUT_VALID),
    .out_data(OUT_DATA),
    .out_ready(OUT_READY)
  );

endmodule // delay_phase_resampler
`default_nettype wire

// ==== resampler_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module resampler_checker
  import resampler_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic OUT_VALID,
  input wire out_sample_t OUT_DATA,
  input wire logic OUT_READY,
  input wire logic RANGE_ERR
);
  logic [BEAM_W-1:0] beam, next_beam;
  logic [4:0] run, next_run;
  default clocking @(posedge CLK); endclocking
  // Expected beam of next pop, length of ready run
  always_comb
  begin
    next_beam = beam + BEAM_W'(OUT_VALID && OUT_READY);
    next_run = OUT_READY ? run + 5'(run != 5'h1F) : 5'h00;
    if (SYS_RST)
    begin
      next_beam = '0;
      next_run = '0;
    end
  end
  always_ff @(posedge CLK)
  begin
    beam <= next_beam;
    run <= next_run;
  end
  reset_flags_a: assert property (SYS_RST |=> !IN_READY && !OUT_VALID && !RANGE_ERR)
    else $error("flags not cleared by reset");
  reset_data_a: assert property (SYS_RST |=> OUT_DATA == '0)
    else $error("output data not cleared by reset");
  ready_rise_a: assert property (disable iff (SYS_RST)
    $fell(SYS_RST) |-> !IN_READY ##[1:2] IN_READY) else $error("input ready late");
  fill_wait_a: assert property (disable iff (SYS_RST)
    $fell(SYS_RST) |-> !OUT_VALID [*4] ##1 (!OUT_VALID || RANGE_ERR))
    else $error("output before any sample");
  hold_valid_a: assert property (disable iff (SYS_RST)
    OUT_VALID && !OUT_READY |=> OUT_VALID) else $error("output dropped unpopped");
  hold_data_a: assert property (disable iff (SYS_RST)
    OUT_VALID && !OUT_READY |=> $stable(OUT_DATA)) else $error("output changed unpopped");
  beam_order_a: assert property (disable iff (SYS_RST)
    OUT_VALID && OUT_READY |-> OUT_DATA.beam == beam) else $error("beam out of order");
  out_pace_a: assert property (disable iff (SYS_RST)
    run >= 5'h10 && OUT_VALID && OUT_READY |=> !OUT_VALID [*3])
    else $error("outputs faster than engine");
  cover property (OUT_VALID && !OUT_READY);
  cover property (RANGE_ERR);
  cover property (IN_VALID && !IN_READY);
endmodule // resampler_checker
bind delay_phase_resampler resampler_checker resampler_checker_inst (.CLK, .SYS_RST,
  .IN_VALID, .IN_READY, .OUT_VALID, .OUT_DATA, .OUT_READY, .RANGE_ERR);
`default_nettype wire

// ==== slice_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module slice_source
  import resampler_pkg::*;
(
  input wire logic clk,
  input wire logic run,
  input wire logic signed [SAMP_W-1:0] base,
  input wire logic signed [SAMP_W-1:0] step,
  input wire logic ready,
  output logic valid,
  output sample_t data
);
  int n;
  logic taken;
  initial
  begin
    n = 0;
    valid = 1'b0;
    data = '0;
  end
  // Hold until taken, scramble lines when idle
  always @(posedge clk)
  begin
    taken = valid && ready;
    #1;
    n = run ? n + int'(taken) : 0;
    valid = run;
    data.re = run ? base + step * SAMP_W'(n) : ~data.re;
    data.im = run ? '0 : ~data.im;
  end
endmodule // slice_source
`default_nettype wire

// ==== delay_phase_resampler_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module delay_phase_resampler_test
  import resampler_pkg::*;
;
  logic clk, rst, run, in_valid, in_ready, out_valid, out_ready, range_err;
  logic signed [SAMP_W-1:0] base, step;
  logic [BUF_AW-1:0] coarse;
  logic signed [FRAC_W-1:0] fine;
  logic [RATE_W-1:0] rate;
  logic [PHASE_W-1:0] fstep, poff;
  beam_model_t [NUM_BEAMS-1:0] bm;
  sample_t in_data;
  out_sample_t out_data;
  out_sample_t got [0:7];
  int num_errors, cmp_count;
  slice_source slice_source_inst (.clk(clk), .run(run), .base(base), .step(step),
    .ready(in_ready), .valid(in_valid), .data(in_data));
  delay_phase_resampler delay_phase_resampler_inst (.CLK(clk), .SYS_RST(rst),
    .IN_VALID(in_valid), .IN_DATA(in_data), .IN_READY(in_ready), .COARSE_DELAY(coarse),
    .FINE_DELAY(fine), .RATE_STEP(rate), .FREQ_STEP(fstep), .PHASE_OFFSET(poff),
    .BEAM_MODEL(bm), .OUT_VALID(out_valid), .OUT_DATA(out_data), .OUT_READY(out_ready),
    .RANGE_ERR(range_err));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [37:0] seen, input logic [37:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("Compares %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task restart(input logic signed [SAMP_W-1:0] b, input logic signed [SAMP_W-1:0] s);
    run = 1'b0;
    rst = 1'b1;
    base = b;
    step = s;
    repeat (16) tick();
    rst = 1'b0;
    run = 1'b1;
  endtask
  task collect(input int n);
    int k, t;
    k = 0;
    t = 0;
    out_ready = 1'b1;
    while (k < n && t < 3000)
    begin
      @(negedge clk);
      t++;
      if (out_valid === 1'b1)
      begin
        got[k] = out_data;
        k++;
      end
      @(posedge clk);
    end
    check(38'(k), 38'(n));
    #1;
  endtask
  task t_phase;
    logic signed [OUT_W-1:0] a [0:3];
    out_sample_t e;
    tick();
    a = '{18'sd4095, 18'sd0, -18'sd4096, 18'sd0};
    poff = 18'h10000;
    fstep = 18'h10000;
    // Keep read point inside stored samples
    fine = -10'sh2;
    for (int b = 0; b < NUM_BEAMS; b++)
      bm[b].phase = PHASE_W'(b << 16);
    restart(16'sh1000, 16'sh0);
    collect(8);
    for (int k = 0; k < 8; k++)
    begin
      e = '{BEAM_W'(k), a[(k % 4 + k / 4 + 1) % 4], a[(k % 4 + k / 4) % 4]};
      check(got[k], e);
    end
  endtask
  task t_interp;
    tick();
    poff = '0;
    fstep = '0;
    // Mid-step offset so the dithered LSB cannot move the result
    fine = -10'sh8;
    rate = 24'h080000;
    for (int b = 0; b < NUM_BEAMS; b++)
      bm[b] = '{BDLY_W'(-b * 256), '0};
    restart(16'sh40, 16'sh40);
    collect(8);
    for (int k = 0; k < 8; k++)
    begin
      check(38'(got[k].re - got[0].re), 38'(32 * (k / 4) + 16 * (k % 4)));
      check(38'(got[k].im), 38'h0);
    end
  endtask
  task t_range;
    tick();
    coarse = 12'hFFF;
    fine = '0;
    // Beam delay pushes the read point past the buffer depth
    for (int b = 0; b < NUM_BEAMS; b++)
      bm[b] = '{16'sh4000, '0};
    restart(16'sh64, 16'sh0);
    collect(4);
    for (int k = 0; k < 4; k++)
      check(got[k], {BEAM_W'(k), 36'h0});
    check(38'(range_err), 38'h1);
  endtask
  task t_stall;
    int n;
    tick();
    n = 0;
    coarse = '0;
    fine = -10'sh8;
    bm = '0;
    out_ready = 1'b0;
    restart(16'sh100, 16'sh0);
    repeat (120) tick();
    check(38'(in_ready), 38'h1);
    out_ready = 1'b1;
    repeat (8)
    begin
      @(negedge clk);
      n += int'(out_valid === 1'b1 && out_data.re === 18'sd255);
    end
    check(38'(n), 38'd8);
    #1;
  endtask
  initial
  begin
    rst = 1'b1;
    run = 1'b0;
    base = '0;
    step = '0;
    coarse = '0;
    fine = '0;
    rate = 24'h100000;
    fstep = '0;
    poff = '0;
    bm = '0;
    out_ready = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    t_phase();
    t_interp();
    t_range();
    t_stall();
    report_and_stop();
  end
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule // delay_phase_resampler_test
`default_nettype wire
